// >>> common/add_sub_pkg.sv
/*
 * Shared constants for the eight-bit add/subtract slice with load override:
 * data width, register offsets, field positions and reset values.
 * Assumes a single clock domain and a plain word-wide register port.
 */
`default_nettype none

package add_sub_pkg;

    // operand and result width of one slice
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MSB_POS = 7;

    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned WORD_W = 32;

    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // control register fields
    localparam int unsigned CTRL_SUB_POS = 0;
    localparam logic CTRL_SUB_RESET = 1'h0;

    // status register fields
    localparam int unsigned STATUS_TOTAL_POS = 0;
    localparam int unsigned STATUS_CARRY_POS = 8;
    localparam int unsigned STATUS_LOAD_POS = 9;

    // read data when nothing is read or the offset is unmapped
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage : add_sub_pkg

`default_nettype wire

// >>> hdl/add_sub_slice_core.sv
/*
 * Ripple-carry eight-bit adder with optional inversion of the right operand
 * and a load override on the result.
 * Assumes nothing of its surroundings: pure combinational logic, no clock.
 */
`timescale 1ns/1ps
`default_nettype none

module add_sub_slice_core
(
    input wire logic [7:0] left_term,
    input wire logic [7:0] right_term,
    input wire logic [7:0] init_value,
    input wire logic load,
    input wire logic carry_input,
    input wire logic subtract_select,
    output logic [7:0] total_out,
    output logic carry_output
);

    ////////////////////////////////////////////////////////////////////////
    // operand preparation

    // right operand inverted for subtraction; carry_input supplies the +1
    wire logic [7:0] addend;
    assign addend = subtract_select ? ~right_term : right_term;

    ////////////////////////////////////////////////////////////////////////
    // ripple carry chain

    // carry chain: chain[0] is carry_input, chain[8] leaves the slice
    wire logic [8:0] chain;
    wire logic [7:0] raw_sum;
    assign chain[0] = carry_input;

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < add_sub_pkg::DATA_W; bit_idx++)
        begin : g_ripple
            // full adder per bit, no state anywhere
            assign raw_sum[bit_idx] = left_term[bit_idx] ^ addend[bit_idx] ^ chain[bit_idx];
            assign chain[bit_idx + 1] = (left_term[bit_idx] & addend[bit_idx])
                | (chain[bit_idx] & (left_term[bit_idx] ^ addend[bit_idx]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // load wins over any arithmetic, whatever the operands or carry
    assign total_out = load ? init_value : raw_sum;
    // carry out of the top bit; kept live in both modes so slices can chain
    assign carry_output = chain[add_sub_pkg::DATA_W];

endmodule : add_sub_slice_core

`default_nettype wire

// >>> hdl/eight_bit_add_sub_load.sv
/*
 * Top of the eight-bit add/subtract slice: the combinational datapath plus a
 * small register port holding the add/subtract selection and showing status.
 * Assumes operands, load value, load and carry come from user logic in the
 * ref_clk domain; wider words are built by chaining carries outside.
 */
`timescale 1ns/1ps
`default_nettype none

module eight_bit_add_sub_load
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] left_term,
    input wire logic [7:0] right_term,
    input wire logic [7:0] init_value,
    input wire logic load,
    input wire logic carry_input,
    output logic [7:0] total_out,
    output logic carry_output,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // address decoding

    // offset match, shared by the write and read paths
    function automatic logic hits(input logic [3:0] addr, input logic [3:0] offset);
        hits = (addr == offset);
    endfunction : hits

    wire logic wr_ctrl;
    wire logic rd_ctrl;
    wire logic rd_status;
    wire logic rd_unmapped;
    assign wr_ctrl = reg_write & hits(reg_addr, add_sub_pkg::CTRL_OFFSET);
    assign rd_ctrl = reg_read & hits(reg_addr, add_sub_pkg::CTRL_OFFSET);
    assign rd_status = reg_read & hits(reg_addr, add_sub_pkg::STATUS_OFFSET);
    assign rd_unmapped = reg_read & ~rd_ctrl & ~rd_status;

    ////////////////////////////////////////////////////////////////////////
    // control register: add/subtract selection

    logic subtract_select_ff;
    wire logic nxt_subtract_select;
    // static mode bit; software should change it only while results are unused
    assign nxt_subtract_select = wr_ctrl ? reg_wdata[add_sub_pkg::CTRL_SUB_POS] : subtract_select_ff;

    // selection defaults to addition out of reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            subtract_select_ff <= add_sub_pkg::CTRL_SUB_RESET;
        else
            subtract_select_ff <= nxt_subtract_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath

    // combinational on purpose: a register here would break carry chaining
    add_sub_slice_core u_core
    (
        .left_term(left_term),
        .right_term(right_term),
        .init_value(init_value),
        .load(load),
        .carry_input(carry_input),
        .subtract_select(subtract_select_ff),
        .total_out(total_out),
        .carry_output(carry_output)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path

    // status word shows the live result, carry and load level
    wire logic [31:0] status_word;
    wire logic [31:0] ctrl_word;
    assign status_word = {22'h0, load, carry_output, total_out};
    assign ctrl_word = {31'h0, subtract_select_ff};

    wire logic [31:0] nxt_reg_rdata;
    assign nxt_reg_rdata = rd_ctrl ? ctrl_word :
                           rd_status ? status_word :
                           add_sub_pkg::RDATA_IDLE;

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= add_sub_pkg::RDATA_IDLE;
        else
            reg_rdata <= nxt_reg_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the datapath and register port

    // reference results for each operating case: nine bits for addition, eight for subtraction
    wire logic [8:0] ref_add;
    wire logic [7:0] ref_sub;
    wire logic [7:0] ref_sub_less_one;
    assign ref_add = {1'b0, left_term} + {1'b0, right_term} + {8'h00, carry_input};
    assign ref_sub = left_term - right_term;
    assign ref_sub_less_one = left_term - right_term - 8'h01;

    // signed view of an addition without carry in, used for the sign check
    wire logic signed [8:0] ref_signed_sum;
    assign ref_signed_sum = $signed({left_term[7], left_term}) + $signed({right_term[7], right_term});

    a_load_priority: assert property (@(posedge ref_clk) disable iff (rst)
        load |-> total_out == init_value)
        else $error("load did not force the result to the load value");

    a_add_result: assert property (@(posedge ref_clk) disable iff (rst)
        (!load && !subtract_select_ff) |-> total_out == ref_add[7:0])
        else $error("addition result wrong");

    a_sub_exact: assert property (@(posedge ref_clk) disable iff (rst)
        (!load && subtract_select_ff && carry_input) |-> total_out == ref_sub)
        else $error("subtraction with carry in high wrong");

    a_sub_less_one: assert property (@(posedge ref_clk) disable iff (rst)
        (!load && subtract_select_ff && !carry_input) |-> total_out == ref_sub_less_one)
        else $error("subtraction with carry in low wrong");

    a_add_carry_out: assert property (@(posedge ref_clk) disable iff (rst)
        !subtract_select_ff |-> carry_output == ref_add[8])
        else $error("carry out of addition wrong");

    a_signed_sum: assert property (@(posedge ref_clk) disable iff (rst)
        (!load && !subtract_select_ff && !carry_input
            && ref_signed_sum >= -9'sd128 && ref_signed_sum <= 9'sd127)
        |-> $signed(total_out) == ref_signed_sum[7:0])
        else $error("signed sum in range not reproduced");

    // a mode write takes effect on the next edge and steers the datapath
    sequence s_mode_write;
        wr_ctrl && !rst;
    endsequence

    a_mode_takes: assert property (@(posedge ref_clk) disable iff (rst)
        s_mode_write ##1 !load |-> (total_out == (subtract_select_ff ? left_term - right_term - {7'h00, ~carry_input}
            : ref_add[7:0])))
        else $error("mode write did not steer the datapath");

    a_mode_reset: assert property (@(posedge ref_clk)
        rst |=> !subtract_select_ff)
        else $error("subtraction selected after reset");

    a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
        rd_status |=> reg_rdata == {22'h0, $past(load), $past(carry_output), $past(total_out)})
        else $error("status read did not return live result");

    a_read_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_unmapped || !reg_read) |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a mapped read");

endmodule : eight_bit_add_sub_load

`default_nettype wire

// >>> testbench/lower_slice_model.sv
/*
 * Stand-in for the user logic below the slice: an eight-bit lower word whose carry out feeds the slice's carry in.
 * Assumes it is combinational and that the bench gives it the same mode as the slice.
 */
`timescale 1ns/1ps
`default_nettype none

module lower_slice_model
(
    input wire logic [7:0] low_left,
    input wire logic [7:0] low_right,
    input wire logic sub_mode,
    output logic carry_up
);
    logic [8:0] low_sum;

    // lowest slice takes carry high when subtracting, upper slices do not
    assign low_sum = {1'b0, low_left} + {1'b0, sub_mode ? ~low_right : low_right} + {8'h00, sub_mode};
    // carry of the lower word goes up to the next slice
    assign carry_up = low_sum[8];
endmodule : lower_slice_model

`default_nettype wire

// >>> testbench/tb_eight_bit_add_sub_load.sv
/*
 * Self-checking bench for the add/subtract slice: random operands, load and carry, both modes, chained carries.
 * Assumes the register map of the shared package and a combinational datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_eight_bit_add_sub_load;
    logic ref_clk, rst, load, cin, use_chain, sub_mode, carry_input, carry_output, reg_write, reg_read, chain_carry;
    logic [7:0] left_term, right_term, init_value, low_left, low_right, total_out;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int bad_count, tests_run;

    eight_bit_add_sub_load dut (.ref_clk(ref_clk), .rst(rst), .left_term(left_term), .right_term(right_term),
        .init_value(init_value), .load(load), .carry_input(carry_input), .total_out(total_out),
        .carry_output(carry_output), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata));
    lower_slice_model lower (.low_left(low_left), .low_right(low_right), .sub_mode(sub_mode), .carry_up(chain_carry));

    ////////////////////////////////////////////////////////////////////////////
    // clock and carry routing; chained runs take the lower word's carry
    always #2.5 ref_clk = ~ref_clk;
    assign carry_input = use_chain ? chain_carry : cin;

    task check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            bad_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task stop_test();
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // bus tasks start right after a rising edge and end on one
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] a);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(posedge ref_clk);
        rd = reg_rdata;
    endtask : rd_reg

    ////////////////////////////////////////////////////////////////////////////
    // one random vector; model works in integers, checked off the edge
    task vec(input bit m);
        logic [7:0] l, r, d, ll, lr, rb, lrb, want;
        logic ld, ci, ch;
        int cl, ce, s;
        l = $urandom;
        r = $urandom;
        d = $urandom;
        ll = $urandom;
        lr = $urandom;
        ld = ($urandom % 4) == 0;
        ci = $urandom;
        ch = $urandom;
        // invert at eight bits first, so the cast cannot widen the inversion
        rb = m ? ~r : r;
        lrb = m ? ~lr : lr;
        cl = (int'(ll) + int'(lrb) + int'(m)) >> 8;
        ce = ch ? cl : ci;
        s = int'(l) + int'(rb) + ce;
        want = ld ? d : s[7:0];
        left_term <= l;
        right_term <= r;
        init_value <= d;
        low_left <= ll;
        low_right <= lr;
        load <= ld;
        cin <= ci;
        use_chain <= ch;
        #1;
        check(total_out, want);
        if (!ld)
            check(carry_output, s[8]);
        @(posedge ref_clk);
        rd_reg(add_sub_pkg::STATUS_OFFSET);
        check({rd[31:9], rd[7:0]}, {22'h0, ld, want});
        if (!ld)
            check(rd[8], s[8]);
    endtask : vec

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, register checks, then both modes
    initial
    begin
        {ref_clk, load, cin, use_chain, sub_mode, reg_write, reg_read} = 7'h00;
        rst = 1'b1;
        {left_term, right_term, init_value, low_left, low_right} = 40'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        void'($urandom(52));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd_reg(add_sub_pkg::CTRL_OFFSET);
        check(rd, 32'h0000_0000);
        rd_reg(4'h8);
        check(rd, add_sub_pkg::RDATA_IDLE);
        for (int m = 0; m < 2; m++)
        begin
            sub_mode <= m[0];
            wr_reg(add_sub_pkg::CTRL_OFFSET, m);
            rd_reg(add_sub_pkg::CTRL_OFFSET);
            wr_reg(add_sub_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
            check(rd, m);
            repeat (60) vec(m[0]);
        end
        // mid-run reset must fall back to addition
        rst <= 1'b1;
        sub_mode <= 1'b0;
        @(posedge ref_clk);
        rst <= 1'b0;
        rd_reg(add_sub_pkg::CTRL_OFFSET);
        check(rd, 32'h0000_0000);
        repeat (8) vec(1'b0);
        stop_test();
    end

    // watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #20000;
        bad_count++;
        stop_test();
    end
endmodule : tb_eight_bit_add_sub_load

`default_nettype wire
